// file: hw/dmcr_main.sv
/*
 main control register of a dual-channel interpolating converter.
 assumes a simple strobe bus synchronous to clk_sys, read data one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dmcr_map.svh"
module dmcr_main
   import dmcr_pkg::*;
(
   input  wire logic        clk_sys,          // 200 MHz system clock
   input  wire logic        rst,              // async reset, high
   input  wire logic [6:0]  bus_addr,         // register address
   input  wire logic [15:0] bus_wdata,        // write data
   input  wire logic        bus_wr,           // write strobe
   input  wire logic        bus_rd,           // read strobe
   output var  logic [15:0] bus_rdata,        // read data, cycle after rd
   input  wire logic        sync_pulse,       // selected sync source event
   input  wire logic        alarm_in,         // internal alarm, active high
   output var  logic        offset_corr_ena,  // offset stage in path
   output var  logic        phase_gain_ena,   // phase/gain stage in path
   output var  logic [4:0]  interp_factor,    // one-hot 1x..16x
   output var  logic        interp_bad,       // code was undefined
   output var  logic        fifo_ena,         // input fifo in path
   output var  logic        invsinc_ena,      // inverse sinc in path
   output var  logic        clkdiv_resync,    // one-cycle divider restart
   output var  logic        alarm_pin_out,    // alarm pin level
   output var  logic        alarm_pin_oe_n    // low while pin driven
);
   logic [15:0] ctrl_reg;
   logic [15:0] ctrl_next;
   logic [15:0] rdata_next;
   dmcr_bus_s   bus;
   dmcr_ctrl_s  dec;

   assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

   wire hit_ctrl = bus.addr == `DMCR_OFS_MAIN_CONTROL;
   wire wr_ctrl  = bus.wr && hit_ctrl;

   // reserved bits are stored as written; software keeps them at default
   assign ctrl_next = wr_ctrl ? bus.wdata : ctrl_reg;
   // unmapped reads answer zero
   assign rdata_next = (bus.rd && hit_ctrl) ? ctrl_reg : 16'h0000;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_reg  <= `DMCR_RST_MAIN_CONTROL;
         bus_rdata <= 16'h0000;
      end else begin
         ctrl_reg  <= ctrl_next;
         bus_rdata <= rdata_next;
      end
   end

   wire [3:0] interp_code = ctrl_reg[`DMCR_BIT_INTERP_HI:`DMCR_BIT_INTERP_LO];

   // undefined codes fall back to 8x, the reset factor, and raise a flag
   always_comb begin
      dec             = '0;
      dec.offset_ena  = ctrl_reg[`DMCR_BIT_OFFSET_ENA];
      dec.corr_ena    = ctrl_reg[`DMCR_BIT_CORR_ENA];
      dec.fifo_ena    = ctrl_reg[`DMCR_BIT_FIFO_ENA];
      dec.invsinc_ena = ctrl_reg[`DMCR_BIT_INVSINC_ENA];
      case (interp_code)
         `DMCR_INTERP_1X:  dec.interp = DMCR_X1;
         `DMCR_INTERP_2X:  dec.interp = DMCR_X2;
         `DMCR_INTERP_4X:  dec.interp = DMCR_X4;
         `DMCR_INTERP_8X:  dec.interp = DMCR_X8;
         `DMCR_INTERP_16X: dec.interp = DMCR_X16;
         default: begin
            dec.interp     = DMCR_X8;
            dec.interp_bad = 1'b1;
         end
      endcase
   end

   wire [4:0] factor_next = 5'h01 << dec.interp;
   // resync only on a sync event while enabled, so dividers restart aligned
   wire resync_next = sync_pulse && ctrl_reg[`DMCR_BIT_CLKDIV_SYNC];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         offset_corr_ena <= 1'b0;
         phase_gain_ena  <= 1'b0;
         interp_factor   <= 5'h08;
         interp_bad      <= 1'b0;
         fifo_ena        <= 1'b1;
         invsinc_ena     <= 1'b0;
         clkdiv_resync   <= 1'b0;
      end else begin
         offset_corr_ena <= dec.offset_ena;
         phase_gain_ena  <= dec.corr_ena;
         interp_factor   <= factor_next;
         interp_bad      <= dec.interp_bad;
         fifo_ena        <= dec.fifo_ena;
         invsinc_ena     <= dec.invsinc_ena;
         clkdiv_resync   <= resync_next;
      end
   end

   dmcr_alarm_pin u_alarm (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .alarm_in  (alarm_in),
      .drive_ena (ctrl_reg[`DMCR_BIT_ALARM_OE]),
      .pol_high  (ctrl_reg[`DMCR_BIT_ALARM_POL]),
      .pin_out   (alarm_pin_out),
      .pin_oe_n  (alarm_pin_oe_n)
   );

   sequence wr_seq;
      bus_wr && bus_addr == `DMCR_OFS_MAIN_CONTROL;
   endsequence

   sequence rd_seq;
      bus_rd && bus_addr == `DMCR_OFS_MAIN_CONTROL;
   endsequence

   write_store_a: assert property (@(posedge clk_sys) disable iff (rst)
      wr_seq |=> ctrl_reg == $past(bus_wdata))
      else $error("control write not stored");
   read_back_a: assert property (@(posedge clk_sys) disable iff (rst)
      rd_seq |=> bus_rdata == $past(ctrl_reg))
      else $error("control read data wrong");
   offset_ena_a: assert property (@(posedge clk_sys) disable iff (rst)
      wr_seq ##1 1'b1 |=> offset_corr_ena == $past(bus_wdata, 2) >> 15)
      else $error("offset enable not following");
   corr_ena_a: assert property (@(posedge clk_sys) disable iff (rst)
      wr_seq |=> ##1 phase_gain_ena == $past(ctrl_reg[13]))
      else $error("phase gain enable not following");
   interp_map_a: assert property (@(posedge clk_sys) disable iff (rst)
      ctrl_reg[11:8] == 4'h8 |=> interp_factor == 5'h10)
      else $error("16x factor wrong");
   interp_bad_a: assert property (@(posedge clk_sys) disable iff (rst)
      ctrl_reg[11:8] == 4'h3 |=> interp_bad && interp_factor == 5'h08)
      else $error("undefined code not mapped");
   fifo_path_a: assert property (@(posedge clk_sys) disable iff (rst)
      1'b1 |=> fifo_ena == $past(ctrl_reg[7]))
      else $error("fifo enable not following");
   invsinc_path_a: assert property (@(posedge clk_sys) disable iff (rst)
      1'b1 |=> invsinc_ena == $past(ctrl_reg[1]))
      else $error("inverse sinc enable not following");
   resync_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
      clkdiv_resync |-> $past(sync_pulse) && $past(ctrl_reg[2]))
      else $error("resync without enabled sync");
   oe_track_a: assert property (@(posedge clk_sys) disable iff (rst)
      1'b1 |=> alarm_pin_oe_n == !$past(ctrl_reg[4]))
      else $error("alarm drive enable wrong");

   // a write reaches the decoded outputs one edge after it lands
   sequence wr_settle_seq;
      wr_seq ##1 1'b1;
   endsequence

   sequence sync_armed_seq;
      sync_pulse && ctrl_reg[`DMCR_BIT_CLKDIV_SYNC];
   endsequence

   // read strobe right behind a write must see the new word
   sequence wr_rd_seq;
      wr_seq ##1 rd_seq;
   endsequence

   // reset state, seen at the first edge after release
   reset_value_a: assert property (@(posedge clk_sys)
      $fell(rst) |-> ctrl_reg == `DMCR_RST_MAIN_CONTROL)
      else $error("control reset value wrong");

   reset_outputs_a: assert property (@(posedge clk_sys)
      $fell(rst) |-> interp_factor == 5'h08 && fifo_ena && !interp_bad)
      else $error("decoded reset state wrong");

   reset_stages_a: assert property (@(posedge clk_sys)
      $fell(rst) |-> !offset_corr_ena && !phase_gain_ena && !invsinc_ena && !clkdiv_resync)
      else $error("stage enables not off after reset");

   pin_reset_a: assert property (@(posedge clk_sys)
      $fell(rst) |-> !alarm_pin_oe_n && !alarm_pin_out)
      else $error("alarm pin reset state wrong");

   // bus side: only offset zero is mapped
   unmapped_wr_a: assert property (@(posedge clk_sys) disable iff (rst)
      bus_wr && !hit_ctrl |=> ctrl_reg == $past(ctrl_reg))
      else $error("unmapped write changed control");

   unmapped_rd_a: assert property (@(posedge clk_sys) disable iff (rst)
      bus_rd && !hit_ctrl |=> bus_rdata == 16'h0000)
      else $error("unmapped read not zero");

   idle_rdata_a: assert property (@(posedge clk_sys) disable iff (rst)
      !bus_rd |=> bus_rdata == 16'h0000)
      else $error("read data outside read cycle");

   rsvd_stored_a: assert property (@(posedge clk_sys) disable iff (rst)
      wr_seq |=> (ctrl_reg & `DMCR_RSVD_MASK) == ($past(bus_wdata) & `DMCR_RSVD_MASK))
      else $error("reserved bits not stored");

   wr_then_rd_a: assert property (@(posedge clk_sys) disable iff (rst)
      wr_rd_seq |=> bus_rdata == $past(bus_wdata, 2))
      else $error("read after write stale");

   // field outputs, two edges after the write edge
   offset_lvl_a: assert property (@(posedge clk_sys) disable iff (rst)
      1'b1 |=> offset_corr_ena == $past(ctrl_reg[`DMCR_BIT_OFFSET_ENA]))
      else $error("offset enable level wrong");

   corr_settle_a: assert property (@(posedge clk_sys) disable iff (rst)
      wr_settle_seq |=> phase_gain_ena == $past(bus_wdata[`DMCR_BIT_CORR_ENA], 2))
      else $error("phase gain enable late");

   fifo_settle_a: assert property (@(posedge clk_sys) disable iff (rst)
      wr_settle_seq |=> fifo_ena == $past(bus_wdata[`DMCR_BIT_FIFO_ENA], 2))
      else $error("fifo enable late");

   invsinc_settle_a: assert property (@(posedge clk_sys) disable iff (rst)
      wr_settle_seq |=> invsinc_ena == $past(bus_wdata[`DMCR_BIT_INVSINC_ENA], 2))
      else $error("inverse sinc enable late");

   oe_settle_a: assert property (@(posedge clk_sys) disable iff (rst)
      wr_settle_seq |=> alarm_pin_oe_n == !$past(bus_wdata[`DMCR_BIT_ALARM_OE], 2))
      else $error("alarm drive enable late");

   // alarm pin: drive comes back one edge after the enable rises
   drive_rise_a: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(ctrl_reg[`DMCR_BIT_ALARM_OE]) |=> !alarm_pin_oe_n)
      else $error("alarm pin not driven");

   pol_low_a: assert property (@(posedge clk_sys) disable iff (rst)
      !ctrl_reg[`DMCR_BIT_ALARM_POL] |=> alarm_pin_out == !$past(alarm_in))
      else $error("negative alarm polarity wrong");

   pol_high_a: assert property (@(posedge clk_sys) disable iff (rst)
      ctrl_reg[`DMCR_BIT_ALARM_POL] |=> alarm_pin_out == $past(alarm_in))
      else $error("positive alarm polarity wrong");

   // interpolation: always exactly one factor selected
   interp_onehot_a: assert property (@(posedge clk_sys) disable iff (rst)
      1'b1 |=> $onehot(interp_factor))
      else $error("interpolation factor not one-hot");

   interp_good_a: assert property (@(posedge clk_sys) disable iff (rst)
      interp_code inside {`DMCR_INTERP_1X, `DMCR_INTERP_2X, `DMCR_INTERP_4X, `DMCR_INTERP_8X,
                          `DMCR_INTERP_16X} |=> !interp_bad)
      else $error("defined code flagged bad");

   localparam logic [3:0] INTERP_CODES [5] = '{`DMCR_INTERP_1X, `DMCR_INTERP_2X, `DMCR_INTERP_4X,
                                              `DMCR_INTERP_8X, `DMCR_INTERP_16X};

   // one check per defined code: entry n selects factor bit n
   for (genvar g = 0; g < 5; g++) begin : g_interp_chk
      interp_code_a: assert property (@(posedge clk_sys) disable iff (rst)
         interp_code == INTERP_CODES[g] |=> interp_factor == 5'(1 << g))
         else $error("interpolation factor wrong");
   end

   // resync: fires on an armed sync event and never otherwise
   resync_fire_a: assert property (@(posedge clk_sys) disable iff (rst)
      sync_armed_seq |=> clkdiv_resync)
      else $error("armed sync did not resync");

   resync_off_a: assert property (@(posedge clk_sys) disable iff (rst)
      !ctrl_reg[`DMCR_BIT_CLKDIV_SYNC] |=> !clkdiv_resync)
      else $error("resync while disabled");

   resync_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
      !sync_pulse |=> !clkdiv_resync)
      else $error("resync without sync event");
endmodule : dmcr_main
`default_nettype wire

// file: hw/dmcr_map.svh
/*
 main control register map: offsets, field positions, reset value.
 assumes inclusion by bare name from the two modules; the package does not include it.
*/
// Functional notes
// - control register at offset zero, sixteen bits, resets to 0x049c.
// - bit 15 enables offset correction stage, else bypassed, default zero.
// - bit 13 enables phase and gain correction, else bypassed, default zero.
// - bits 11:8 pick interpolation 1x,2x,4x,8x,16x; default 8x.
// - bit 7 puts input FIFO in data path; default one.
// - bit 4 set drives alarm pin, clear tristates it; default one.
// - bit 3 alarm polarity, 0 active low, 1 active high; default one.
// - bit 2 resyncs divided clocks from selected sync source; default one.
// - bit 1 inserts inverse sinc filter, else bypassed; default zero.
`ifndef DMCR_MAP_SVH
`define DMCR_MAP_SVH
`define DMCR_OFS_MAIN_CONTROL 7'h00
`define DMCR_RST_MAIN_CONTROL 16'h049c
`define DMCR_BIT_OFFSET_ENA   15
`define DMCR_BIT_CORR_ENA     13
`define DMCR_BIT_INTERP_HI    11
`define DMCR_BIT_INTERP_LO    8
`define DMCR_BIT_FIFO_ENA     7
`define DMCR_BIT_ALARM_OE     4
`define DMCR_BIT_ALARM_POL    3
`define DMCR_BIT_CLKDIV_SYNC  2
`define DMCR_BIT_INVSINC_ENA  1
`define DMCR_RSVD_MASK        16'h5061
`define DMCR_INTERP_1X        4'h0
`define DMCR_INTERP_2X        4'h1
`define DMCR_INTERP_4X        4'h2
`define DMCR_INTERP_8X        4'h4
`define DMCR_INTERP_16X       4'h8
`endif

// file: hw/dmcr_pkg.sv
/*
 types for the main control register block.
 assumes the map header is on the include path.
*/
package dmcr_pkg;
   typedef enum logic [2:0] {
      DMCR_X1  = 3'h0,
      DMCR_X2  = 3'h1,
      DMCR_X4  = 3'h2,
      DMCR_X8  = 3'h3,
      DMCR_X16 = 3'h4
   } dmcr_interp_e;

   typedef struct packed {
      logic         offset_ena;
      logic         corr_ena;
      dmcr_interp_e interp;
      logic         interp_bad;
      logic         fifo_ena;
      logic         invsinc_ena;
   } dmcr_ctrl_s;

   typedef struct packed {
      logic [6:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } dmcr_bus_s;
endpackage : dmcr_pkg

// file: hw/dmcr_alarm_pin.sv
/*
 alarm pin driver: polarity and drive enable from the control word.
 assumes alarm_in is a synchronous active-high alarm level.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dmcr_map.svh"
module dmcr_alarm_pin
   import dmcr_pkg::*;
(
   input  wire logic clk_sys,   // system clock
   input  wire logic rst,       // async reset, high
   input  wire logic alarm_in,  // internal alarm, active high
   input  wire logic drive_ena, // pin drive request
   input  wire logic pol_high,  // 1 active high pin
   output var  logic pin_out,   // pin level
   output var  logic pin_oe_n   // low while driven
);
   wire pin_level_next = pol_high ? alarm_in : ~alarm_in;
   wire oe_n_next      = ~drive_ena;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_out  <= 1'b0;
         pin_oe_n <= 1'b0;
      end else begin
         pin_out  <= pin_level_next;
         pin_oe_n <= oe_n_next;
      end
   end

   pol_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
      1'b1 |=> pin_out == ($past(pol_high) ? $past(alarm_in) : ~$past(alarm_in)))
      else $error("alarm pin polarity wrong");
   drive_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(drive_ena) |=> pin_oe_n)
      else $error("alarm pin not released");
endmodule : dmcr_alarm_pin
`default_nettype wire

// file: verif/tb.sv
/*
 bench for the main control register: bus tasks, field checks, alarm pin, resync.
 assumes dmcr_pkg and dmcr_main are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
   import dmcr_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic [6:0]  bus_addr = 7'h00;
   logic [15:0] bus_wdata = 16'h0000;
   logic        bus_wr = 1'b0;
   logic        bus_rd = 1'b0;
   logic        sync_pulse = 1'b0;
   logic        alarm_in = 1'b0;
   logic [15:0] bus_rdata, v;
   logic        offset_corr_ena, phase_gain_ena, interp_bad, fifo_ena, invsinc_ena;
   logic        clkdiv_resync, alarm_pin_out, alarm_pin_oe_n;
   logic [4:0]  interp_factor;
   int          fails = 0;
   int          checks_done = 0;
   int          i, n;
   logic [3:0]  codes [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
   always #2.5 clk_sys = ~clk_sys;
   dmcr_main dut_u (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .sync_pulse(sync_pulse),
      .alarm_in(alarm_in), .offset_corr_ena(offset_corr_ena), .phase_gain_ena(phase_gain_ena),
      .interp_factor(interp_factor), .interp_bad(interp_bad), .fifo_ena(fifo_ena),
      .invsinc_ena(invsinc_ena), .clkdiv_resync(clkdiv_resync), .alarm_pin_out(alarm_pin_out),
      .alarm_pin_oe_n(alarm_pin_oe_n));
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge clk_sys);
      bus_wr    <= 1'b0;
   endtask : wr
   task rd(input logic [6:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge clk_sys);
      bus_rd   <= 1'b0;
      #1 d = bus_rdata;
   endtask : rd
   // write then read with no gap between the strobes
   task wr_rd(input logic [15:0] d, output logic [15:0] q);
      @(posedge clk_sys);
      bus_addr  <= 7'h00;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge clk_sys);
      bus_wr    <= 1'b0;
      bus_rd    <= 1'b1;
      @(posedge clk_sys);
      bus_rd    <= 1'b0;
      #1 q = bus_rdata;
   endtask : wr_rd
   // outputs settle two edges after the write edge
   task settle;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask : settle
   // counts resync pulses in the three cycles after one sync event
   task sync_count(output int c);
      @(posedge clk_sys);
      sync_pulse <= 1'b1;
      @(posedge clk_sys);
      sync_pulse <= 1'b0;
      c = 0;
      repeat (3) begin
         #1 c += (clkdiv_resync === 1'b1);
         @(posedge clk_sys);
      end
   endtask : sync_count
   task close_out;
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      rd(7'h00, v);
      chk(v, 16'h049c);
      chk({15'h0, offset_corr_ena}, 16'h0000);
      chk({15'h0, phase_gain_ena}, 16'h0000);
      chk({11'h0, interp_factor}, 16'h0008);
      chk({15'h0, fifo_ena}, 16'h0001);
      chk({15'h0, alarm_pin_oe_n}, 16'h0000);
      chk({15'h0, invsinc_ena}, 16'h0000);
      $display("test reset done");
      // reserved bits kept at zero in every word written
      for (i = 0; i < 5; i++) begin
         wr(7'h00, {4'h0, codes[i], 8'h9c});
         settle();
         chk({11'h0, interp_factor}, 16'h0001 << i);
         chk({15'h0, interp_bad}, 16'h0000);
      end
      wr(7'h00, 16'h039c);
      settle();
      chk({11'h0, interp_factor}, 16'h0008);
      chk({15'h0, interp_bad}, 16'h0001);
      $display("test interpolation done");
      wr(7'h00, 16'ha402);
      settle();
      chk({15'h0, offset_corr_ena}, 16'h0001);
      chk({15'h0, phase_gain_ena}, 16'h0001);
      chk({15'h0, fifo_ena}, 16'h0000);
      chk({15'h0, alarm_pin_oe_n}, 16'h0001);
      chk({15'h0, invsinc_ena}, 16'h0001);
      rd(7'h00, v);
      chk(v, 16'ha402);
      sync_count(n);
      chk(n[15:0], 16'h0000);
      $display("test fields done");
      alarm_in <= 1'b1;
      wr(7'h00, 16'h0494);
      settle();
      chk({15'h0, alarm_pin_out}, 16'h0000);
      chk({15'h0, alarm_pin_oe_n}, 16'h0000);
      wr(7'h00, 16'h049c);
      settle();
      chk({15'h0, alarm_pin_out}, 16'h0001);
      sync_count(n);
      chk(n[15:0], 16'h0001);
      $display("test alarm and sync done");
      wr(7'h01, 16'hffff);
      rd(7'h00, v);
      chk(v, 16'h049c);
      rd(7'h01, v);
      chk(v, 16'h0000);
      $display("test unmapped done");
      wr_rd(16'h229c, v);
      chk(v, 16'h229c);
      chk({15'h0, phase_gain_ena}, 16'h0001);
      chk({11'h0, interp_factor}, 16'h0004);
      $display("test back to back done");
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      rd(7'h00, v);
      chk(v, 16'h049c);
      chk({15'h0, phase_gain_ena}, 16'h0000);
      chk({11'h0, interp_factor}, 16'h0008);
      chk({15'h0, alarm_pin_oe_n}, 16'h0000);
      $display("test mid-run reset done");
      close_out();
   end
endmodule : tb
`default_nettype wire
